//--- verilog/wml_consts.svh
// Purpose: Shared constants for the word move and logic datapath.
// Assumes: Included by bare name wherever a figure is needed.
// Notes: Definitions only.
`ifndef WML_CONSTS_SVH
`define WML_CONSTS_SVH

// ==========================================================================
// Widths
`define WML_WORD_W 16
`define WML_ADDR_W 4
`define WML_MATH_W 32
`define WML_SIGN_BIT 15

// ==========================================================================
// Values
`define WML_ZERO_WORD 16'h0000
`define WML_MOST_NEG 16'h8000
`define WML_MOST_POS 16'h7fff
`define WML_MATH_RESET 32'h0000_0000

`endif

//--- verilog/word_move_pkg.sv
// Purpose: Types shared by both ends of the scan link.
// Assumes: Flag order keeps carry in bit 0 and sign in bit 3.
// Notes: Constants live in wml_consts.svh.
package word_move_pkg;

   typedef enum logic [2:0]
   {
      OP_PLAIN_MOVE = 3'h0,
      OP_MASKED_MOVE = 3'h1,
      OP_AND = 3'h2,
      OP_OR = 3'h3,
      OP_XOR = 3'h4,
      OP_COMPLEMENT = 3'h5,
      OP_TWOS_NEGATE = 3'h6
   } op_type;

   typedef struct packed
   {
      logic sign;
      logic zero;
      logic overflow;
      logic carry;
   } flags_type;

   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b01,
      SEQ_WAIT = 2'b10
   } seq_state_type;

endpackage : word_move_pkg

//--- verilog/scan_link_if.sv
// Purpose: Link between the scan sequencer and the word datapath.
// Assumes: Both ends drive their signals from flip-flops on one clock.
// Notes: Operand fields hold an immediate or a word address.
`timescale 1ns/100ps
`include "wml_consts.svh"
interface scan_link_if #(
   parameter int ADDR_W = `WML_ADDR_W
);
   logic req_valid;
   logic req_rung;
   word_move_pkg::op_type req_op;
   logic [`WML_WORD_W-1:0] req_a;
   logic req_a_const;
   logic [`WML_WORD_W-1:0] req_b;
   logic req_b_const;
   logic [ADDR_W-1:0] req_dest;
   logic eop;
   logic rsp_done;
   logic [`WML_WORD_W-1:0] rsp_result;
   word_move_pkg::flags_type rsp_flags;

   modport sequencer
   (
      output req_valid, req_rung, req_op, req_a, req_a_const,
      output req_b, req_b_const, req_dest, eop,
      input rsp_done, rsp_result, rsp_flags
   );

   modport unit
   (
      input req_valid, req_rung, req_op, req_a, req_a_const,
      input req_b, req_b_const, req_dest, eop,
      output rsp_done, rsp_result, rsp_flags
   );
endinterface : scan_link_if

//--- verilog/word_op_core.sv
// Purpose: Combinational result and flag logic for one instruction.
// Assumes: Operands already fetched; words are two's complement.
// Notes: No state; the owning unit decides whether to commit.
`timescale 1ns/100ps
`include "wml_consts.svh"
module word_op_core
(
   input wire word_move_pkg::op_type op_i,
   input wire logic [`WML_WORD_W-1:0] a_i,
   input wire logic [`WML_WORD_W-1:0] b_i,
   input wire logic [`WML_WORD_W-1:0] dest_old_i,
   input wire logic sat_disable_i,
   output logic [`WML_WORD_W-1:0] result_o,
   output word_move_pkg::flags_type flags_o,
   output logic trap_o
);

   logic [`WML_WORD_W-1:0] negated;
   logic negate_ovf;

   always_comb
   begin
      negated = `WML_WORD_W'(~a_i + 1'b1);
      negate_ovf = (a_i == `WML_MOST_NEG);
      trap_o = 1'b0;
      flags_o.carry = 1'b0;
      flags_o.overflow = 1'b0;
      unique case (op_i)
         word_move_pkg::OP_PLAIN_MOVE: result_o = a_i;
         word_move_pkg::OP_MASKED_MOVE:
            result_o = (a_i & b_i) | (dest_old_i & ~b_i);
         word_move_pkg::OP_AND: result_o = a_i & b_i;
         word_move_pkg::OP_OR: result_o = a_i | b_i;
         word_move_pkg::OP_XOR: result_o = a_i ^ b_i;
         word_move_pkg::OP_COMPLEMENT: result_o = ~a_i;
         word_move_pkg::OP_TWOS_NEGATE:
         begin
            // Saturate unless software asked for the raw wrap
            if (negate_ovf && !sat_disable_i)
            begin
               result_o = `WML_MOST_POS;
            end
            else
            begin
               result_o = negated;
            end
            flags_o.overflow = negate_ovf;
            trap_o = negate_ovf;
            flags_o.carry = !(negate_ovf
               || negated == `WML_ZERO_WORD);
         end
         default: result_o = dest_old_i;
      endcase
      flags_o.zero = (result_o == `WML_ZERO_WORD);
      flags_o.sign = result_o[`WML_SIGN_BIT];
   end

endmodule : word_op_core

//--- verilog/word_move_logic_unit.sv
// Purpose: Datapath end: data table, flags and error latches.
// Assumes: One request per instruction per scan from the sequencer.
// Notes: Answer comes one cycle after the request is taken.
//    A false rung still answers, with the old word and old flags.
//    Load and instruction on one word in one cycle: instruction wins.
//    Major fault stays until reset; only the minor error unlatches.
//    Operand addresses use the low bits of the 16-bit field.
//    Math word changes only through its own load port.
//
// How it works
// - Move and logic ops clear carry, overflow; zero test
// - Sign flag follows result bit 15
// - Masked move: mask ones pass, zeros keep
// - Mask is immediate or fetched word
// - Masked move repeats every true scan
// - And writes bitwise conjunction to destination
// - Or writes bitwise disjunction to destination
// - Exclusive or marks differing bits
// - Complement inverts every source bit
// - Issuer: two constants only for plain move; word destination
// - Issuer: complement, negate use addresses only
// - Negate stores two's complement
// - Negate overflow only at most negative; trap
// - Overflow saturates to largest positive
// - Saturation disabled keeps truncated result
// - Negate carry clear on zero or overflow
// - Plain move copies source every true scan
// - Minor error at end of program faults
// - Math register untouched by these ops
`timescale 1ns/100ps
`include "wml_consts.svh"
module word_move_logic_unit #(
   parameter int ADDR_W = `WML_ADDR_W
)
(
   input wire logic clk_i,
   input wire logic srst_i,
   scan_link_if.unit link,
   input wire logic sat_disable_i,
   input wire logic minor_clr_i,
   input wire logic load_en_i,
   input wire logic [ADDR_W-1:0] load_addr_i,
   input wire logic [`WML_WORD_W-1:0] load_data_i,
   input wire logic math_load_i,
   input wire logic [`WML_MATH_W-1:0] math_data_i,
   input wire logic [ADDR_W-1:0] peek_addr_i,
   output logic [`WML_WORD_W-1:0] peek_data_o,
   output word_move_pkg::flags_type flags_o,
   output logic minor_err_o,
   output logic major_fault_o,
   output logic [`WML_MATH_W-1:0] math_reg_o
);

   localparam int DEPTH = 1 << ADDR_W;

   // ========================================================================
   // State
   typedef struct packed
   {
      logic [DEPTH-1:0][`WML_WORD_W-1:0] mem;
      word_move_pkg::flags_type flags;
      logic minor;
      logic major;
      logic [`WML_MATH_W-1:0] math;
      logic rsp_done;
      logic [`WML_WORD_W-1:0] rsp_result;
      word_move_pkg::flags_type rsp_flags;
      logic [`WML_WORD_W-1:0] peek;
   } unit_state_type;

   unit_state_type st_q;
   unit_state_type st_d;

   logic [`WML_WORD_W-1:0] opnd_a;
   logic [`WML_WORD_W-1:0] opnd_b;
   logic [`WML_WORD_W-1:0] dest_old;
   logic [`WML_WORD_W-1:0] core_result;
   word_move_pkg::flags_type core_flags;
   logic core_trap;
   logic commit;

   // ========================================================================
   // Operand fetch
   // Table read by index
   function automatic logic [`WML_WORD_W-1:0] word_at
   (
      input logic [DEPTH-1:0][`WML_WORD_W-1:0] mem,
      input logic [ADDR_W-1:0] addr
   );
      return mem[addr];
   endfunction : word_at

   // Immediate or table word, picked per operand
   function automatic logic [`WML_WORD_W-1:0] fetch
   (
      input logic [DEPTH-1:0][`WML_WORD_W-1:0] mem,
      input logic [`WML_WORD_W-1:0] field,
      input logic is_const
   );
      if (is_const)
      begin
         return field;
      end
      return word_at(mem, field[ADDR_W-1:0]);
   endfunction : fetch

   always_comb
   begin
      opnd_a = fetch(st_q.mem, link.req_a, link.req_a_const);
      // Mask may change at run time when fetched from a word
      opnd_b = fetch(st_q.mem, link.req_b, link.req_b_const);
      dest_old = word_at(st_q.mem, link.req_dest);
      commit = link.req_valid && link.req_rung;
   end

   word_op_core word_op_core_inst
   (
      .op_i(link.req_op),
      .a_i(opnd_a),
      .b_i(opnd_b),
      .dest_old_i(dest_old),
      .sat_disable_i(sat_disable_i),
      .result_o(core_result),
      .flags_o(core_flags),
      .trap_o(core_trap)
   );

   // ========================================================================
   // Error latches
   // Set wins over clear when both land in one cycle
   function automatic logic latch_next
   (
      input logic held,
      input logic clr,
      input logic hit
   );
      if (hit)
      begin
         return 1'b1;
      end
      if (clr)
      begin
         return 1'b0;
      end
      return held;
   endfunction : latch_next

   // ========================================================================
   // Next state
   always_comb
   begin
      st_d = st_q;
      st_d.rsp_done = 1'b0;
      if (load_en_i)
      begin
         st_d.mem[load_addr_i] = load_data_i;
      end
      // Only the math load port reaches this word
      if (math_load_i)
      begin
         st_d.math = math_data_i;
      end
      if (link.req_valid)
      begin
         st_d.rsp_done = 1'b1;
         st_d.rsp_result = dest_old;
         st_d.rsp_flags = st_q.flags;
         // No edge detect: every true request executes
         if (commit)
         begin
            st_d.mem[link.req_dest] = core_result;
            st_d.flags = core_flags;
            st_d.rsp_result = core_result;
            st_d.rsp_flags = core_flags;
         end
      end
      st_d.minor = latch_next(st_q.minor, minor_clr_i,
         commit && core_trap);
      st_d.major = latch_next(st_q.major, 1'b0,
         link.eop && st_d.minor);
      st_d.peek = word_at(st_q.mem, peek_addr_i);
   end

   // ========================================================================
   // Registers
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ========================================================================
   // Link answer
   assign link.rsp_done = st_q.rsp_done;
   assign link.rsp_result = st_q.rsp_result;
   assign link.rsp_flags = st_q.rsp_flags;

   // ========================================================================
   // Outputs
   assign peek_data_o = st_q.peek;
   assign flags_o = st_q.flags;
   assign minor_err_o = st_q.minor;
   assign major_fault_o = st_q.major;
   assign math_reg_o = st_q.math;

endmodule : word_move_logic_unit

//--- verilog/scan_sequencer_end.sv
// Purpose: Sequencer end: issues one instruction, waits for answer.
// Assumes: User offers a command each scan while it wants it executed.
// Notes: Illegal operand forms are refused, never sent.
`timescale 1ns/100ps
`include "wml_consts.svh"
module scan_sequencer_end #(
   parameter int ADDR_W = `WML_ADDR_W
)
(
   input wire logic clk_i,
   input wire logic srst_i,
   scan_link_if.sequencer link,
   input wire logic cmd_valid_i,
   input wire logic cmd_rung_i,
   input wire word_move_pkg::op_type cmd_op_i,
   input wire logic [`WML_WORD_W-1:0] cmd_a_i,
   input wire logic cmd_a_const_i,
   input wire logic [`WML_WORD_W-1:0] cmd_b_i,
   input wire logic cmd_b_const_i,
   input wire logic [ADDR_W-1:0] cmd_dest_i,
   input wire logic end_scan_i,
   output logic cmd_ready_o,
   output logic cmd_reject_o,
   output logic done_o,
   output logic [`WML_WORD_W-1:0] result_o,
   output word_move_pkg::flags_type flags_o
);

   typedef struct packed
   {
      word_move_pkg::seq_state_type state;
      logic ready;
      logic reject;
      logic done;
      logic [`WML_WORD_W-1:0] result;
      word_move_pkg::flags_type flags;
      logic req_valid;
      logic req_rung;
      word_move_pkg::op_type req_op;
      logic [`WML_WORD_W-1:0] req_a;
      logic req_a_const;
      logic [`WML_WORD_W-1:0] req_b;
      logic req_b_const;
      logic [ADDR_W-1:0] req_dest;
      logic eop;
   } seq_type;

   seq_type st_q;
   seq_type st_d;

   // ========================================================================
   // Operand form check
   function automatic logic legal
   (
      input word_move_pkg::op_type op,
      input logic a_const,
      input logic b_const
   );
      unique case (op)
         word_move_pkg::OP_PLAIN_MOVE: return 1'b1;
         word_move_pkg::OP_MASKED_MOVE: return !a_const;
         word_move_pkg::OP_AND,
         word_move_pkg::OP_OR,
         word_move_pkg::OP_XOR: return !(a_const && b_const);
         word_move_pkg::OP_COMPLEMENT,
         word_move_pkg::OP_TWOS_NEGATE: return !a_const;
         default: return 1'b0;
      endcase
   endfunction : legal

   always_comb
   begin
      st_d = st_q;
      st_d.reject = 1'b0;
      st_d.done = 1'b0;
      st_d.req_valid = 1'b0;
      st_d.eop = end_scan_i;
      unique case (st_q.state)
         word_move_pkg::SEQ_IDLE:
         begin
            if (cmd_valid_i && st_q.ready)
            begin
               if (!legal(cmd_op_i, cmd_a_const_i, cmd_b_const_i))
               begin
                  st_d.reject = 1'b1;
               end
               else
               begin
                  st_d.req_valid = 1'b1;
                  st_d.req_rung = cmd_rung_i;
                  st_d.req_op = cmd_op_i;
                  st_d.req_a = cmd_a_i;
                  st_d.req_a_const = cmd_a_const_i;
                  st_d.req_b = cmd_b_i;
                  st_d.req_b_const = cmd_b_const_i;
                  st_d.req_dest = cmd_dest_i;
                  st_d.ready = 1'b0;
                  st_d.state = word_move_pkg::SEQ_WAIT;
               end
            end
         end
         word_move_pkg::SEQ_WAIT:
         begin
            if (link.rsp_done)
            begin
               st_d.done = 1'b1;
               st_d.result = link.rsp_result;
               st_d.flags = link.rsp_flags;
               st_d.ready = 1'b1;
               st_d.state = word_move_pkg::SEQ_IDLE;
            end
         end
         default:
         begin
            st_d.ready = 1'b1;
            st_d.state = word_move_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         st_q <= '0;
         st_q.state <= word_move_pkg::SEQ_IDLE;
         st_q.ready <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign link.req_valid = st_q.req_valid;
   assign link.req_rung = st_q.req_rung;
   assign link.req_op = st_q.req_op;
   assign link.req_a = st_q.req_a;
   assign link.req_a_const = st_q.req_a_const;
   assign link.req_b = st_q.req_b;
   assign link.req_b_const = st_q.req_b_const;
   assign link.req_dest = st_q.req_dest;
   assign link.eop = st_q.eop;
   assign cmd_ready_o = st_q.ready;
   assign cmd_reject_o = st_q.reject;
   assign done_o = st_q.done;
   assign result_o = st_q.result;
   assign flags_o = st_q.flags;

endmodule : scan_sequencer_end

//--- bench/scan_link_checker_sva.sv
// Purpose: Checks answers on the scan link.
// Assumes: One clock; reset synchronous, active high.
// Notes: Old table words are unseen here, so masks are checked in the bench.
`timescale 1ns/100ps
`include "wml_consts.svh"
module scan_link_checker_sva
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic req_valid,
   input wire logic req_rung,
   input wire word_move_pkg::op_type req_op,
   input wire logic [`WML_WORD_W-1:0] req_a,
   input wire logic req_a_const,
   input wire logic rsp_done,
   input wire logic [`WML_WORD_W-1:0] rsp_result,
   input wire word_move_pkg::flags_type rsp_flags
);
   logic fire;
   logic negate_fire;
   assign fire = req_valid && req_rung;
   assign negate_fire = fire && req_op == word_move_pkg::OP_TWOS_NEGATE;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   // ======================================================================
   // Answers and flags
   property p_answer;
      req_valid |=> rsp_done;
   endproperty
   a_answer: assert property (p_answer)
      else $error("no answer after request");
   property p_logic_flags;
      fire && req_op != word_move_pkg::OP_TWOS_NEGATE |=> !rsp_flags.carry
         && !rsp_flags.overflow && rsp_flags.zero == (rsp_result == '0);
   endproperty
   a_logic_flags: assert property (p_logic_flags)
      else $error("move or logic flags wrong");
   property p_sign;
      fire |=> rsp_flags.sign == rsp_result[`WML_SIGN_BIT];
   endproperty
   a_sign: assert property (p_sign)
      else $error("sign flag wrong");
   property p_move_const;
      fire && req_op == word_move_pkg::OP_PLAIN_MOVE && req_a_const
         |=> rsp_result == $past(req_a);
   endproperty
   a_move_const: assert property (p_move_const)
      else $error("move result wrong");
   // Only the immediate operand is visible, so bounds not exact values
   property p_and_const;
      fire && req_op == word_move_pkg::OP_AND && req_a_const
         |=> (rsp_result & ~$past(req_a)) == '0;
   endproperty
   a_and_const: assert property (p_and_const)
      else $error("and result has extra bits");
   property p_or_const;
      fire && req_op == word_move_pkg::OP_OR && req_a_const
         |=> (rsp_result & $past(req_a)) == $past(req_a);
   endproperty
   a_or_const: assert property (p_or_const)
      else $error("or result lost bits");
   property p_negate_ovf;
      negate_fire ##1 rsp_flags.overflow |-> rsp_result == `WML_MOST_POS
         || rsp_result == `WML_MOST_NEG;
   endproperty
   a_negate_ovf: assert property (p_negate_ovf)
      else $error("negate overflow result wrong");
   property p_negate_carry;
      negate_fire |=> rsp_flags.carry
         == (!rsp_flags.overflow && rsp_result != '0);
   endproperty
   a_negate_carry: assert property (p_negate_carry)
      else $error("negate carry wrong");
   property p_false_rung;
      req_valid && !req_rung |=> rsp_flags == $past(rsp_flags);
   endproperty
   a_false_rung: assert property (p_false_rung)
      else $error("false rung changed flags");
endmodule : scan_link_checker_sva

//--- bench/word_move_logic_unit_tb_top.sv
// Purpose: Drives both link ends through the sequencer command side.
// Assumes: Table depth 16; each command waits for done or reject.
// Notes: Expected words are worked by hand from the operations.
`timescale 1ns/100ps
module word_move_logic_unit_tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic sat_disable_i, minor_clr_i, load_en_i, math_load_i, end_scan_i;
   logic cmd_valid_i, cmd_rung_i, cmd_a_const_i, cmd_b_const_i;
   logic [3:0] load_addr_i, peek_addr_i, cmd_dest_i;
   logic [15:0] load_data_i, cmd_a_i, cmd_b_i, peek_data_o, result_o;
   logic [31:0] math_data_i, math_reg_o;
   word_move_pkg::op_type cmd_op_i;
   word_move_pkg::flags_type unit_flags, seq_flags;
   logic minor_err_o, major_fault_o, cmd_ready_o, cmd_reject_o, done_o;
   int err_total = 0;
   int n_checks = 0;

   always #20 clk_i = ~clk_i;

   scan_link_if scan_link_if_inst ();
   word_move_logic_unit word_move_logic_unit_inst (.clk_i, .srst_i,
      .link(scan_link_if_inst), .sat_disable_i, .minor_clr_i, .load_en_i,
      .load_addr_i, .load_data_i, .math_load_i, .math_data_i, .peek_addr_i,
      .peek_data_o, .flags_o(unit_flags), .minor_err_o, .major_fault_o,
      .math_reg_o);
   scan_sequencer_end scan_sequencer_end_inst (.clk_i, .srst_i,
      .link(scan_link_if_inst), .cmd_valid_i, .cmd_rung_i, .cmd_op_i,
      .cmd_a_i, .cmd_a_const_i, .cmd_b_i, .cmd_b_const_i, .cmd_dest_i,
      .end_scan_i, .cmd_ready_o, .cmd_reject_o, .done_o, .result_o,
      .flags_o(seq_flags));
   scan_link_checker_sva scan_link_checker_sva_inst (.clk_i, .srst_i,
      .req_valid(scan_link_if_inst.req_valid),
      .req_rung(scan_link_if_inst.req_rung),
      .req_op(scan_link_if_inst.req_op),
      .req_a(scan_link_if_inst.req_a),
      .req_a_const(scan_link_if_inst.req_a_const),
      .rsp_done(scan_link_if_inst.rsp_done),
      .rsp_result(scan_link_if_inst.rsp_result),
      .rsp_flags(scan_link_if_inst.rsp_flags));

   // ======================================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   task automatic ld(input logic [3:0] ad, input logic [15:0] dt);
      {load_en_i, load_addr_i, load_data_i} = {1'b1, ad, dt};
      @(negedge clk_i);
      load_en_i = 1'b0;
   endtask : ld

   task automatic pk(input logic [3:0] ad, input logic [15:0] e);
      peek_addr_i = ad;
      @(negedge clk_i);
      chk("peek", peek_data_o, e);
   endtask : pk

   task automatic eop_chk(input logic e);
      end_scan_i = 1'b1;
      @(negedge clk_i);
      end_scan_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("major", major_fault_o, e);
   endtask : eop_chk

   // f holds rung, a immediate, b immediate, expect refusal
   task automatic run(input logic [2:0] o, input logic [3:0] f,
      input logic [15:0] a, input logic [15:0] b, input logic [3:0] d,
      input logic [15:0] er, input logic [3:0] ef);
      int n;
      n = 0;
      cmd_op_i = word_move_pkg::op_type'(o);
      {cmd_rung_i, cmd_a_const_i, cmd_b_const_i} = f[3:1];
      {cmd_a_i, cmd_b_i, cmd_dest_i} = {a, b, d};
      cmd_valid_i = 1'b1;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      while (done_o !== 1'b1 && cmd_reject_o !== 1'b1 && n < 8)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 8)
         err_total++;
      chk("reject", cmd_reject_o, f[0]);
      chk("ready", cmd_ready_o, 32'h0000_0001);
      if (!f[0])
      begin
         chk("result", result_o, er);
         chk("flags", seq_flags, ef);
         chk("unit flags", unit_flags, ef);
      end
   endtask : run

   // All operands immediate: every form but plain move is refused
   task automatic refuse(input logic [2:0] o);
      run(o, 4'hf, 16'h0005, 16'h0005, 4'h8, 16'h0000, 4'h0);
   endtask : refuse

   // ======================================================================
   // Tests
   initial
   begin
      {sat_disable_i, minor_clr_i, load_en_i, end_scan_i, cmd_valid_i,
         cmd_rung_i, cmd_a_const_i, cmd_b_const_i} = '0;
      {load_addr_i, peek_addr_i, cmd_dest_i, load_data_i, cmd_a_i,
         cmd_b_i} = '0;
      {math_load_i, math_data_i} = {1'b1, 32'h1234_abcd};
      cmd_op_i = word_move_pkg::OP_PLAIN_MOVE;
      repeat (10) @(negedge clk_i);
      srst_i = 1'b0;
      ld(4'h1, 16'h8000);
      math_load_i = 1'b0;
      ld(4'h2, 16'h00f0);
      ld(4'h3, 16'h1234);
      ld(4'h6, 16'hffff);
      ld(4'ha, 16'hffff);
      run(3'h0, 4'hc, 16'h0000, 16'h0000, 4'h4, 16'h0000, 4'h4);
      run(3'h0, 4'h8, 16'h0001, 16'h0000, 4'h5, 16'h8000, 4'h8);
      pk(4'h5, 16'h8000);
      $display("test moves done");
      run(3'h1, 4'ha, 16'h0003, 16'h00ff, 4'h6, 16'hff34, 4'h8);
      run(3'h1, 4'h8, 16'h0003, 16'h0002, 4'h7, 16'h0030, 4'h0);
      ld(4'h3, 16'h5678);
      run(3'h1, 4'h8, 16'h0003, 16'h0002, 4'h7, 16'h0070, 4'h0);
      pk(4'h6, 16'hff34);
      $display("test masked move done");
      run(3'h2, 4'hc, 16'h0ff0, 16'h0003, 4'h8, 16'h0670, 4'h0);
      run(3'h3, 4'hc, 16'h0ff0, 16'h0003, 4'h8, 16'h5ff8, 4'h0);
      run(3'h4, 4'hc, 16'h0ff0, 16'h0003, 4'h8, 16'h5988, 4'h0);
      run(3'h4, 4'ha, 16'h0003, 16'h5678, 4'h8, 16'h0000, 4'h4);
      run(3'h5, 4'h8, 16'h0003, 16'h0000, 4'h8, 16'ha987, 4'h8);
      run(3'h2, 4'hc, 16'h8000, 16'h0006, 4'h8, 16'h8000, 4'h8);
      $display("test logic done");
      run(3'h6, 4'h8, 16'h0003, 16'h0000, 4'h9, 16'ha988, 4'h9);
      run(3'h6, 4'h8, 16'h0000, 16'h0000, 4'h9, 16'h0000, 4'h4);
      run(3'h6, 4'h8, 16'h000a, 16'h0000, 4'h9, 16'h0001, 4'h1);
      chk("minor", minor_err_o, 32'h0000_0000);
      run(3'h6, 4'h8, 16'h0001, 16'h0000, 4'hb, 16'h7fff, 4'h2);
      chk("minor", minor_err_o, 32'h0000_0001);
      sat_disable_i = 1'b1;
      run(3'h6, 4'h8, 16'h0001, 16'h0000, 4'hb, 16'h8000, 4'ha);
      pk(4'hb, 16'h8000);
      // Word moved by the load path leaves the flags alone
      ld(4'hd, 16'h0000);
      chk("load flags", unit_flags, 32'h0000_000a);
      $display("test negate done");
      run(3'h0, 4'h4, 16'h1234, 16'h0000, 4'h4, 16'h0000, 4'ha);
      pk(4'h4, 16'h0000);
      for (int i = 1; i < 7; i++)
      begin
         refuse(i[2:0]);
      end
      pk(4'h8, 16'h8000);
      $display("test refusals done");
      minor_clr_i = 1'b1;
      @(negedge clk_i);
      minor_clr_i = 1'b0;
      chk("minor", minor_err_o, 32'h0000_0000);
      eop_chk(1'b0);
      run(3'h6, 4'h8, 16'h0001, 16'h0000, 4'hc, 16'h8000, 4'ha);
      eop_chk(1'b1);
      chk("math", math_reg_o, 32'h1234_abcd);
      $display("test errors done");
      wrap_up();
   end

   // Generous bound: the sequence needs well under 400 cycles
   initial
   begin
      repeat (2000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end
endmodule : word_move_logic_unit_tb_top
